// file: hdl/nsw_pkg.sv
// normal space wait timing: register map, field layout, timing codes
// assumes one 25 MHz bus clock and a plain register port
package nsw_pkg;
	// register indices (word addresses)
	localparam logic [3:0]  AREA0_WAIT_OFS      = 4'h0;
	localparam logic [3:0]  AREA6A_WAIT_OFS     = 4'h1;
	localparam logic [3:0]  AREA6B_WAIT_OFS     = 4'h2;
	localparam logic [3:0]  AREA0_TYPE_OFS      = 4'h3;
	localparam logic [3:0]  AREA6A_TYPE_OFS     = 4'h4;
	localparam logic [3:0]  AREA6B_TYPE_OFS     = 4'h5;
	localparam logic [3:0]  STATUS_OFS          = 4'h6;
	// wait register fields
	localparam int          SETUP_LSB           = 11;
	localparam int          WAIT_LSB            = 7;
	localparam int          MASK_BIT            = 6;
	localparam int          HOLD_LSB            = 0;
	localparam logic [31:0] WAIT_WRITE_MASK     = 32'h0000_1fc3;
	localparam logic [31:0] WAIT_RESET          = 32'h0000_0500;
	// memory type codes, normal group only
	localparam logic [2:0]  TYPE_NORMAL         = 3'h0;
	localparam logic [2:0]  TYPE_BYTE_SRAM      = 3'h1;
	localparam logic [2:0]  TYPE_MUXED_IO       = 3'h4;
	localparam logic [2:0]  TYPE_RESET          = 3'h0;
	localparam int          CLK_MHZ             = 25;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_WAIT  = 3'b010,
		ST_EXT   = 3'b011,
		ST_HOLD  = 3'b100
	} ctl_state_type;

	typedef struct packed {
		logic [1:0] setup;
		logic [3:0] wait_code;
		logic       mask;
		logic [1:0] hold;
	} wait_cfg_type;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [1:0]  area;
		logic [25:0] addr;
	} acc_req_type;
endpackage

// file: hdl/wait_decode.sv
// wait code decoder: four-bit access wait code to cycle count
// codes above 1100 saturate to the 1100 count of 24 cycles
`timescale 1ns/1ps
module wait_decode (
	input  wire logic [3:0] code_in,   // access wait code
	output logic      [4:0] cycles_out // wait cycle count
);
	always_comb begin
		case (code_in)
			4'h7:    cycles_out = 5'h08;
			4'h8:    cycles_out = 5'h0a;
			4'h9:    cycles_out = 5'h0c;
			4'ha:    cycles_out = 5'h0e;
			4'hb:    cycles_out = 5'h12;
			4'hc:    cycles_out = 5'h18;
			default: cycles_out = (code_in > 4'hc) ? 5'h18 : {1'b0, code_in};
		endcase
	end
endmodule // wait_decode

// file: hdl/nsw_ctrl.sv
// normal space wait controller for areas 0, 6A, 6B
// assumes ext_wait_in asynchronous; strobes counted in half bus cycles
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module nsw_ctrl (
	input  wire logic                sys_clk_in,     // bus clock
	input  wire logic                srst_in,        // sync reset, high
	input  wire logic [3:0]          reg_addr_in,    // register index
	input  wire logic [31:0]         reg_wdata_in,   // write data
	input  wire logic                reg_wr_in,      // write strobe
	input  wire logic                reg_rd_in,      // read strobe
	output logic      [31:0]         reg_rdata_out,  // read data
	input  wire nsw_pkg::acc_req_type acc_in,        // access request
	output logic                     acc_ready_out,  // request taken
	output logic                     acc_done_out,   // access finished
	output logic                     acc_err_out,    // area not normal type
	input  wire logic                ext_wait_in,    // external wait pin
	output logic [25:0]              addr_out,       // address
	output logic [2:0]               area_select_strobe_n_out, // area select
	output logic                     rd_n_out,       // read strobe
	output logic                     we_n_out        // write strobe
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] wait_reg [3];
	logic [2:0]  type_reg [3];
	logic [1:0]  ext_sync_reg;
	nsw_pkg::ctl_state_type state_reg;
	logic [5:0]  half_cnt_reg;
	logic [1:0]  area_reg;
	logic        wr_reg;
	nsw_pkg::wait_cfg_type cfg;
	logic [4:0]  wait_cycles;
	logic        ext_wait;

	function automatic logic [1:0] area_of(input logic [3:0] a, input logic [3:0] base);
		area_of = 2'(a - base);
	endfunction

	function automatic logic is_normal(input logic [2:0] t);
		is_normal = (t == nsw_pkg::TYPE_NORMAL) || (t == nsw_pkg::TYPE_BYTE_SRAM)
			|| (t == nsw_pkg::TYPE_MUXED_IO);
	endfunction

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < 3; i++) begin
				wait_reg[i] <= nsw_pkg::WAIT_RESET;
				type_reg[i] <= nsw_pkg::TYPE_RESET;
			end
		end else if (reg_wr_in) begin
			if (reg_addr_in <= nsw_pkg::AREA6B_WAIT_OFS)
				wait_reg[area_of(reg_addr_in, nsw_pkg::AREA0_WAIT_OFS)] <=
					reg_wdata_in & nsw_pkg::WAIT_WRITE_MASK;
			else if (reg_addr_in <= nsw_pkg::AREA6B_TYPE_OFS)
				type_reg[area_of(reg_addr_in, nsw_pkg::AREA0_TYPE_OFS)] <= reg_wdata_in[2:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			reg_rdata_out <= 32'h0000_0000;
		else if (reg_rd_in) begin
			if (reg_addr_in <= nsw_pkg::AREA6B_WAIT_OFS)
				reg_rdata_out <= wait_reg[area_of(reg_addr_in, nsw_pkg::AREA0_WAIT_OFS)]
					& nsw_pkg::WAIT_WRITE_MASK;
			else if (reg_addr_in <= nsw_pkg::AREA6B_TYPE_OFS)
				reg_rdata_out <= {29'h0, type_reg[area_of(reg_addr_in, nsw_pkg::AREA0_TYPE_OFS)]};
			else if (reg_addr_in == nsw_pkg::STATUS_OFS)
				reg_rdata_out <= {29'h0, state_reg};
			else
				reg_rdata_out <= 32'h0000_0000;
		end else
			reg_rdata_out <= 32'h0000_0000;
	end

	// ----------------------------------------
	// field decode of the selected area
	// ----------------------------------------
	always_comb begin
		cfg.setup     = wait_reg[area_reg][nsw_pkg::SETUP_LSB +: 2];
		cfg.wait_code = wait_reg[area_reg][nsw_pkg::WAIT_LSB +: 4];
		cfg.mask      = wait_reg[area_reg][nsw_pkg::MASK_BIT];
		cfg.hold      = wait_reg[area_reg][nsw_pkg::HOLD_LSB +: 2];
	end

	wait_decode u_wait_decode (
		.code_in    (cfg.wait_code),
		.cycles_out (wait_cycles)
	);

	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			ext_sync_reg <= 2'b00;
		else
			ext_sync_reg <= {ext_sync_reg[0], ext_wait_in};
	end

	assign ext_wait = ext_sync_reg[1] & ~cfg.mask;

	// ----------------------------------------
	// access sequencer, counts half cycles
	// ----------------------------------------
	logic area_ok;
	assign area_ok = (acc_in.area != 2'd3) && is_normal(type_reg[acc_in.area]);
	assign acc_ready_out = (state_reg == nsw_pkg::ST_IDLE);

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg    <= nsw_pkg::ST_IDLE;
			half_cnt_reg <= 6'h00;
			area_reg     <= 2'd0;
			wr_reg       <= 1'b0;
			addr_out     <= 26'h0;
			acc_done_out <= 1'b0;
			acc_err_out  <= 1'b0;
		end else begin
			acc_done_out <= 1'b0;
			acc_err_out  <= 1'b0;
			case (state_reg)
				nsw_pkg::ST_IDLE: begin
					if (acc_in.req && area_ok) begin
						area_reg     <= acc_in.area;
						wr_reg       <= acc_in.wr;
						addr_out     <= acc_in.addr;
						half_cnt_reg <= 6'h00;
						// zero setup: strobe follows select by the half cycle only
						if (wait_reg[acc_in.area][nsw_pkg::SETUP_LSB +: 2] == 2'b00)
							state_reg <= nsw_pkg::ST_WAIT;
						else
							state_reg <= nsw_pkg::ST_SETUP;
					end else if (acc_in.req)
						acc_err_out <= 1'b1;
				end
				nsw_pkg::ST_SETUP: begin
					// n full cycles here, the half cycle comes from the strobe flop
					if ((half_cnt_reg + 6'h2) >= {3'h0, cfg.setup, 1'b0}) begin
						half_cnt_reg <= 6'h00;
						state_reg    <= nsw_pkg::ST_WAIT;
					end else
						half_cnt_reg <= half_cnt_reg + 6'h2;
				end
				nsw_pkg::ST_WAIT: begin
					// one base cycle plus programmed waits
					if (half_cnt_reg >= {wait_cycles, 1'b0}) begin
						half_cnt_reg <= 6'h00;
						state_reg    <= ext_wait ? nsw_pkg::ST_EXT : nsw_pkg::ST_HOLD;
					end else
						half_cnt_reg <= half_cnt_reg + 6'h2;
				end
				nsw_pkg::ST_EXT: begin
					if (!ext_wait)
						state_reg <= nsw_pkg::ST_HOLD;
				end
				nsw_pkg::ST_HOLD: begin
					if (half_cnt_reg >= {3'h0, cfg.hold, 1'b0}) begin
						half_cnt_reg <= 6'h00;
						acc_done_out <= 1'b1;
						state_reg    <= nsw_pkg::ST_IDLE;
					end else
						half_cnt_reg <= half_cnt_reg + 6'h2;
				end
				default: state_reg <= nsw_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// pin strobes; half-cycle offset from negative edge
	// ----------------------------------------
	logic strobe_en;
	logic strobe_half_reg;
	assign strobe_en = (state_reg == nsw_pkg::ST_WAIT) || (state_reg == nsw_pkg::ST_EXT);

	always_ff @(negedge sys_clk_in) begin
		if (srst_in)
			strobe_half_reg <= 1'b0;
		else
			strobe_half_reg <= strobe_en;
	end

	always_comb begin
		area_select_strobe_n_out = 3'b111;
		if (state_reg != nsw_pkg::ST_IDLE)
			area_select_strobe_n_out[area_reg] = 1'b0;
		rd_n_out = ~(strobe_half_reg & ~wr_reg);
		we_n_out = ~(strobe_half_reg & wr_reg);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$past(reg_rd_in) |-> (reg_rdata_out & ~nsw_pkg::WAIT_WRITE_MASK & 32'hffff_fff8) == 0)
		else $error("reserved bits read nonzero");
	a_reset_value: assert property (@(posedge sys_clk_in)
		$past(srst_in) |-> wait_reg[0] == nsw_pkg::WAIT_RESET)
		else $error("wait register reset value wrong");
	a_setup_len: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_IDLE) ##1 (state_reg == nsw_pkg::ST_SETUP)
		|-> ##[1:3] (state_reg == nsw_pkg::ST_WAIT))
		else $error("setup phase length wrong");
	a_wait_len: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$rose(state_reg == nsw_pkg::ST_WAIT) |-> ##[1:25] (state_reg != nsw_pkg::ST_WAIT))
		else $error("wait phase too long");
	a_mask_ignore: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_EXT) |-> !cfg.mask)
		else $error("masked wait extended access");
	a_ext_extend: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_WAIT && half_cnt_reg >= {wait_cycles, 1'b0} && ext_wait)
		|=> state_reg == nsw_pkg::ST_EXT)
		else $error("unmasked wait not honoured");
	a_hold_select: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_HOLD) |-> area_select_strobe_n_out != 3'b111)
		else $error("select dropped in hold");
	a_area_type: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		acc_ready_out && acc_in.req && !area_ok |=> acc_err_out && state_reg == nsw_pkg::ST_IDLE)
		else $error("non-normal area accepted");
	a_ext_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_EXT && ext_wait) |=> state_reg == nsw_pkg::ST_EXT)
		else $error("strobes released under wait");
	a_addr_stable: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg != nsw_pkg::ST_IDLE && $past(state_reg) != nsw_pkg::ST_IDLE)
		|-> $stable(addr_out))
		else $error("address moved during access");
	a_strobe_setup: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == nsw_pkg::ST_IDLE || state_reg == nsw_pkg::ST_SETUP)
		|-> (rd_n_out && we_n_out))
		else $error("strobe low outside strobe phase");
endmodule // nsw_ctrl

// file: sim/mem_wait_model.sv
// external memory wait model: asks for wait a set count of cycles
// assumes low active area selects seen as one combined line
`timescale 1ns/1ps
module mem_wait_model (
	input  wire logic       clk_in,       // bus clock
	input  wire logic       srst_in,      // sync reset, high
	input  wire logic       sel_n_in,     // area selects combined
	input  wire logic [4:0] wait_len_in,  // cycles of wait request
	output logic            ext_wait_out  // wait request, high
);
	logic [4:0] cnt_reg;
	// wait from select fall for wait_len cycles, early enough for the pin synchroniser
	always_ff @(posedge clk_in) begin
		if (srst_in || sel_n_in) begin
			cnt_reg <= 5'h00;
		end else if (cnt_reg != 5'h1f) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
		ext_wait_out <= !srst_in && !sel_n_in && (cnt_reg < wait_len_in);
	end
endmodule // mem_wait_model

// file: sim/normal_space_access_wait_timing_tb_top.sv
// testbench: register port and access timing of the wait controller
// assumes strobe edges on negedge, select edges on posedge
`timescale 1ns/1ps
module normal_space_access_wait_timing_tb_top;
	logic                 clk = 1'b0;
	logic                 srst = 1'b1;
	logic [3:0]           addr = 4'h0;
	logic [31:0]          wdata = 32'h0;
	logic                 wr_s = 1'b0;
	logic                 rd_s = 1'b0;
	logic [31:0]          rdata;
	nsw_pkg::acc_req_type acc_s = '0;
	logic                 ready, done, err, ext_wait, rd_n, we_n;
	logic [25:0]          a_out;
	logic [2:0]           sel_n, sel_seen;
	logic [4:0]           wlen = 5'h00;
	logic [31:0]          d;
	logic                 was_rd, sel_q, st_q, got_err;
	int                   errors, checked, cyc, hc, t_sel, t_fall, t_rise, t_up;
	always #20 clk = ~clk;
	nsw_ctrl u_nsw_ctrl (.sys_clk_in(clk), .srst_in(srst), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.acc_in(acc_s), .acc_ready_out(ready), .acc_done_out(done), .acc_err_out(err),
		.ext_wait_in(ext_wait), .addr_out(a_out), .area_select_strobe_n_out(sel_n),
		.rd_n_out(rd_n), .we_n_out(we_n));
	mem_wait_model u_mem_wait_model (.clk_in(clk), .srst_in(srst), .sel_n_in(&sel_n),
		.wait_len_in(wlen), .ext_wait_out(ext_wait));
	//------------------------------
	// half cycle edge monitor
	//------------------------------
	always @(clk) begin
		#5;
		hc++;
		if (sel_n != 3'h7 && !sel_q) begin
			t_sel = hc;
			sel_seen = sel_n;
		end
		if (sel_n == 3'h7 && sel_q) t_up = hc;
		if (!(rd_n & we_n) && !st_q) begin
			t_fall = hc;
			was_rd = !rd_n;
		end
		if ((rd_n & we_n) && st_q) t_rise = hc;
		sel_q = (sel_n != 3'h7);
		st_q = !(rd_n & we_n);
	end
	//------------------------------
	// tasks
	//------------------------------
	task automatic stop_test();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic access(input logic [1:0] ar, input logic w);
		got_err = 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(ready), 32'h1);
		acc_s <= '{req: 1'b1, wr: w, area: ar, addr: 26'h00abc};
		@(posedge clk);
		acc_s.req <= 1'b0;
		#1;
		for (int n = 0; n < 300 && done !== 1'b1 && err !== 1'b1; n++) @(posedge clk) #1;
		chk(32'(done | err), 32'h1);
		got_err = err;
		// let the edge monitor record the final select rise
		#10;
	endtask
	function automatic int wcyc(input logic [3:0] c);
		return (c < 4'h7) ? int'(c) : (c < 4'hb) ? 2 * int'(c) - 6 : (c == 4'hb) ? 18 : 24;
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			stop_test();
		end
	end
	//------------------------------
	// main sequence
	//------------------------------
	initial begin
		logic [1:0] ar, s, h;
		logic [2:0] ty [3] = '{nsw_pkg::TYPE_NORMAL, nsw_pkg::TYPE_BYTE_SRAM, nsw_pkg::TYPE_MUXED_IO};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			rd(4'(i), d);
			chk(d, 32'h0000_0500);
			wr(4'(i), 32'hffff_ffff);
			rd(4'(i), d);
			chk(d, 32'h0000_1fc3);
		end
		rd(4'hf, d);
		chk(d, 32'h0);
		rd(nsw_pkg::STATUS_OFS, d);
		chk(d, 32'h0);
		for (int c = 0; c < 13; c++) begin
			ar = 2'(c % 3);
			s = 2'(c % 4);
			h = 2'((c + 1) % 4);
			wr(nsw_pkg::AREA0_TYPE_OFS + {2'h0, ar}, {29'h0, ty[(c / 3) % 3]});
			wr({2'h0, ar}, {19'h0, s, 4'(c), 1'b1, 4'h0, h});
			access(ar, c[0]);
			chk(32'(got_err), 32'h0);
			chk({29'h0, sel_seen}, {29'h0, ~(3'h1 << ar)});
			chk(32'(was_rd), 32'(!c[0]));
			chk(32'(t_fall - t_sel), 32'(2 * s + 1));
			chk(32'(t_rise - t_fall), 32'(2 * (wcyc(4'(c)) + 1)));
			chk(32'(t_up - t_rise), 32'(2 * h + 1));
			chk({6'h0, a_out}, 32'h0000_0abc);
		end
		wlen <= 5'h06;
		wr(nsw_pkg::AREA0_TYPE_OFS, 32'h0);
		// zero waits, setup 3 gives the synced wait pin time to arrive
		wr(nsw_pkg::AREA0_WAIT_OFS, 32'h0000_1800);
		access(2'h0, 1'b0);
		chk(32'(t_rise - t_fall >= 12), 32'h1);
		wr(nsw_pkg::AREA0_WAIT_OFS, 32'h0000_0040);
		access(2'h0, 1'b1);
		chk(32'(t_rise - t_fall), 32'h2);
		access(2'h3, 1'b0);
		chk(32'(got_err), 32'h1);
		wr(nsw_pkg::AREA6B_TYPE_OFS, 32'h2);
		rd(nsw_pkg::AREA6B_TYPE_OFS, d);
		chk(d, 32'h0000_0002);
		access(2'h2, 1'b0);
		chk(32'(got_err), 32'h1);
		stop_test();
	end
endmodule // normal_space_access_wait_timing_tb_top
